// *** bim_host.sv ***
// host model: drives the parallel port in the strobe style chosen by style
// assumes bim_top on the same clk; one access at a time, no overlap
`timescale 1ns/1ps
module bim_host
   import bim_pkg::*;
(
   input wire logic clk,
   input wire logic style,
   output logic cs_n,
   output logic rd_ds_n,
   output logic wr_rw,
   output logic [4:0] addr,
   output logic [7:0] dout,
   input wire logic [7:0] din
);
   initial begin
      cs_n = 1'b1;
      rd_ds_n = 1'b1;
      wr_rw = 1'b1;
      addr = 5'h00;
      dout = 8'h00;
   end
   // strobe held over three edges; the next call adds one idle edge
   task automatic acc(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      cs_n <= 1'b0;
      addr <= a;
      dout <= (a == BIM_ADDR_MASK) ? {1'b0, d[6:0]} : d;
      rd_ds_n <= wr & !style;
      wr_rw <= !wr;
      repeat (2) @(posedge clk);
      @(negedge clk) q = din;
      @(posedge clk);
      cs_n <= 1'b1;
      rd_ds_n <= 1'b1;
      wr_rw <= 1'b1;
      dout <= ~dout; // released bus must not show a stale value
   endtask : acc
endmodule : bim_host

// *** bim_pkg.sv ***
// constants shared by the interrupt mask and transmit control block
// assumes one 20 MHz clock; all pins are synchronous to it
package bim_pkg;
   localparam int unsigned BIM_CLK_NS = 50;
   localparam int unsigned BIM_ADDR_W = 5;
   localparam logic [4:0] BIM_ADDR_STATUS = 5'h14;
   localparam logic [4:0] BIM_ADDR_MASK = 5'h15;
   localparam logic [7:0] BIM_MASK_RST = 8'h00;
   localparam logic [6:0] BIM_STAT_RST = 7'h00;
   // status and mask bit positions
   localparam int unsigned BIM_B_ALL_ONES = 6;
   localparam int unsigned BIM_B_ALL_ZEROS = 5;
   localparam int unsigned BIM_B_SYNC_LOST = 4;
   localparam int unsigned BIM_B_BIT_ERR = 3;
   localparam int unsigned BIM_B_BIT_OVF = 2;
   localparam int unsigned BIM_B_ERR_OVF = 1;
   localparam int unsigned BIM_B_SYNC = 0;
   // transmit pattern and its staging fifo
   localparam int unsigned BIM_PAT_LEN = 32;
   localparam int unsigned BIM_PAT_BYTES = 4;
   localparam int unsigned BIM_FIFO_W = 8;
   localparam int unsigned BIM_FIFO_D = 16;
   localparam logic [31:0] BIM_PAT_RST = 32'h0000_0000;
   // parallel port access tracker
   typedef enum logic [1:0] {
      BIM_BUS_IDLE = 2'b00,
      BIM_BUS_READ = 2'b01,
      BIM_BUS_WRITE = 2'b10
   } bim_bus_e;
endpackage : bim_pkg

// *** bim_top.sv ***
// interrupt mask logic, status latching and transmit hold/reload control
// assumes: pins synchronous to clk, tx clock slow enough to be sampled (period >= 2 clk)
//
// What this block does
// - mask bits 0..6 each let the status event at the same position reach the interrupt, 1 enables, 0 masks.
// - bus select low gives separate read and write strobes, high gives data strobe plus read/write line.
// - while tx hold is high at a tx clock rising edge the tx data output keeps its previous bit.
// - a rising edge on the reload input reloads the pattern generator from the programmed pattern.
// - after a reload edge the first new bit appears on tx data at the second tx clock rising edge after it.
// - status bits except sync latch until read; error and overflow clear on read, level ones only if gone.
// - the interrupt pin is driven low while any set status bit is enabled by its mask bit.
`timescale 1ns/1ps

module bim_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_ff;
   logic [AW:0] rd_ptr_ff;
   logic ready_ff;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   wire [AW:0] nxt_wr_ptr = wr_ptr_ff + (AW+1)'(push);
   wire [AW:0] nxt_rd_ptr = rd_ptr_ff + (AW+1)'(pop);
   // extra pointer bit tells full from empty; ready is a flop fed from the next pointers
   assign in_ready = ready_ff;
   assign out_valid = wr_ptr_ff != rd_ptr_ff;
   assign out_data = mem[rd_ptr_ff[AW-1:0]];
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_ff[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         ready_ff <= 1'b1;
      end else begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         ready_ff <= (nxt_wr_ptr[AW] == nxt_rd_ptr[AW]) || (nxt_wr_ptr[AW-1:0] != nxt_rd_ptr[AW-1:0]);
      end
   end
endmodule : bim_fifo

module bim_top
   import bim_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic bus_style_select,
   input wire logic bus_cs_n,
   input wire logic bus_rd_ds_n,
   input wire logic bus_wr_rw,
   input wire logic [BIM_ADDR_W-1:0] bus_addr,
   input wire logic [7:0] bus_data_in,
   output logic [7:0] bus_data_out,
   output logic bus_data_oe,
   input wire logic all_ones_cond,
   input wire logic all_zeros_cond,
   input wire logic sync_lost_cond,
   input wire logic bit_error_evt,
   input wire logic bit_count_ovf_evt,
   input wire logic err_count_ovf_evt,
   input wire logic sync_state,
   output logic int_n_out,
   output logic int_n_oe,
   input wire logic tx_clock,
   input wire logic tx_hold_input,
   input wire logic tx_pattern_reload,
   input wire logic pat_valid,
   output logic pat_ready,
   input wire logic [BIM_FIFO_W-1:0] pat_data,
   output logic tx_data
);
   bim_bus_e bus_st_ff;
   bim_bus_e nxt_bus_st;
   logic [7:0] interrupt_enable_mask_ff;
   logic [6:1] event_status_ff;
   logic [6:1] rd_snap_ff;
   logic [7:0] bus_data_out_ff;
   logic bus_data_oe_ff;
   logic int_n_out_ff;
   logic int_n_oe_ff;
   logic tx_clk_d_ff;
   logic reload_d_ff;
   logic reload_pend_ff;
   logic [BIM_PAT_LEN-1:0] pattern_set_ff;
   logic [BIM_PAT_LEN-1:0] gen_ff;
   logic [4:0] gen_idx_ff;
   logic [1:0] stage_cnt_ff;
   logic stage_full_ff;
   logic tx_data_ff;

   // strobe decode per bus style
   wire rd_act = !bus_cs_n && !bus_rd_ds_n && (bus_style_select ? bus_wr_rw : 1'b1);
   wire wr_act = !bus_cs_n && (bus_style_select ? (!bus_rd_ds_n && !bus_wr_rw) : !bus_wr_rw);
   wire rd_end = (bus_st_ff == BIM_BUS_READ) && !rd_act;
   // addresses are latched at strobe time by the host; sampled live here
   wire hit_status = bus_addr == BIM_ADDR_STATUS;
   wire hit_mask = bus_addr == BIM_ADDR_MASK;

   always_comb begin
      nxt_bus_st = bus_st_ff;
      unique case (bus_st_ff)
         BIM_BUS_IDLE: begin
            if (rd_act) begin
               nxt_bus_st = BIM_BUS_READ;
            end else if (wr_act) begin
               nxt_bus_st = BIM_BUS_WRITE;
            end
         end
         BIM_BUS_READ: begin
            if (!rd_act) begin
               nxt_bus_st = BIM_BUS_IDLE;
            end
         end
         BIM_BUS_WRITE: begin
            if (!wr_act) begin
               nxt_bus_st = BIM_BUS_IDLE;
            end
         end
         default: nxt_bus_st = BIM_BUS_IDLE;
      endcase
   end

   // status events: set wins over a read clear
   wire [6:1] set_vec = {all_ones_cond, all_zeros_cond, sync_lost_cond,
                         bit_error_evt, bit_count_ovf_evt, err_count_ovf_evt};
   wire [6:1] cond_live = {all_ones_cond, all_zeros_cond, sync_lost_cond, 3'b000};
   wire [6:1] clr_vec = rd_end ? (rd_snap_ff & ~cond_live) : 6'h00;
   wire [6:1] nxt_status = (event_status_ff & ~clr_vec) | set_vec;
   wire [6:0] status_all = {event_status_ff, sync_state};
   wire [7:0] status_rd = {1'b0, status_all};
   wire [7:0] rd_mux = hit_status ? status_rd : (hit_mask ? interrupt_enable_mask_ff : 8'h00);
   // mask bit 7 is stored and read back but gates nothing
   wire irq_any = |(status_all & interrupt_enable_mask_ff[6:0]);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus_st_ff <= BIM_BUS_IDLE;
         interrupt_enable_mask_ff <= BIM_MASK_RST;
         event_status_ff <= BIM_STAT_RST[6:1];
         rd_snap_ff <= 6'h00;
         bus_data_out_ff <= 8'h00;
         bus_data_oe_ff <= 1'b0;
      end else begin
         bus_st_ff <= nxt_bus_st;
         event_status_ff <= nxt_status;
         bus_data_oe_ff <= rd_act;
         bus_data_out_ff <= rd_act ? rd_mux : 8'h00;
         // status bits snapped at the last strobe edge are cleared at the end of the read
         if (rd_act && hit_status) begin
            rd_snap_ff <= event_status_ff;
         end else if (rd_end || !rd_act) begin
            rd_snap_ff <= 6'h00;
         end
         if (wr_act && hit_mask) begin
            interrupt_enable_mask_ff <= bus_data_in;
         end
      end
   end

   // open-drain style interrupt: drive low or float
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         int_n_out_ff <= 1'b1;
         int_n_oe_ff <= 1'b0;
      end else begin
         int_n_out_ff <= !irq_any;
         int_n_oe_ff <= irq_any;
      end
   end

   // pattern bytes arrive lsb byte first; staging stalls the fifo until a reload takes it
   logic fifo_out_valid;
   logic [BIM_FIFO_W-1:0] fifo_out_data;
   wire stage_take = fifo_out_valid && !stage_full_ff;
   bim_fifo #(.WIDTH(BIM_FIFO_W), .DEPTH(BIM_FIFO_D)) u_pat_fifo (
      .clk(clk),
      .nrst(nrst),
      .in_valid(pat_valid),
      .in_ready(pat_ready),
      .in_data(pat_data),
      .out_valid(fifo_out_valid),
      .out_ready(!stage_full_ff),
      .out_data(fifo_out_data)
   );

   wire tx_rise = tx_clock && !tx_clk_d_ff;
   wire reload_rise = tx_pattern_reload && !reload_d_ff;
   wire load_now = tx_rise && reload_pend_ff;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_clk_d_ff <= 1'b0;
         reload_d_ff <= 1'b0;
         reload_pend_ff <= 1'b0;
         stage_cnt_ff <= 2'd0;
         stage_full_ff <= 1'b0;
         pattern_set_ff <= BIM_PAT_RST;
      end else begin
         tx_clk_d_ff <= tx_clock;
         reload_d_ff <= tx_pattern_reload;
         if (reload_rise) begin
            reload_pend_ff <= 1'b1;
         end else if (load_now) begin
            reload_pend_ff <= 1'b0;
         end
         if (stage_take) begin
            pattern_set_ff[stage_cnt_ff*8 +: 8] <= fifo_out_data;
            stage_cnt_ff <= stage_cnt_ff + 2'd1;
            stage_full_ff <= stage_cnt_ff == 2'(BIM_PAT_BYTES-1);
         end else if (load_now) begin
            stage_full_ff <= 1'b0;
         end
      end
   end

   // first tx edge after a reload loads the generator, the second shows bit 0
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gen_ff <= BIM_PAT_RST;
         gen_idx_ff <= 5'd0;
         tx_data_ff <= 1'b0;
      end else if (load_now) begin
         gen_ff <= pattern_set_ff;
         gen_idx_ff <= 5'd0;
      end else if (tx_rise && !tx_hold_input) begin
         tx_data_ff <= gen_ff[gen_idx_ff];
         gen_idx_ff <= gen_idx_ff + 5'd1;
      end
   end

   // assertion helper: a load happened and its first bit is not out yet
   logic first_due_ff;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         first_due_ff <= 1'b0;
      end else if (load_now) begin
         first_due_ff <= 1'b1;
      end else if (tx_rise && !tx_hold_input) begin
         first_due_ff <= 1'b0;
      end
   end

   assign bus_data_out = bus_data_out_ff;
   assign bus_data_oe = bus_data_oe_ff;
   assign int_n_out = int_n_out_ff;
   assign int_n_oe = int_n_oe_ff;
   assign tx_data = tx_data_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_reload_seen;
      reload_rise ##1 reload_pend_ff;
   endsequence
   a_irq_drive_low: assert property (irq_any |=> int_n_oe && !int_n_out) else $error("irq not driven");
   a_irq_release: assert property (!irq_any |=> !int_n_oe) else $error("irq not released");
   a_mask_gates: assert property (interrupt_enable_mask_ff[6:0] == 7'h00 |=> !int_n_oe)
      else $error("masked event raised irq");
   a_mask_write: assert property (wr_act && hit_mask |=> interrupt_enable_mask_ff == $past(bus_data_in))
      else $error("mask write lost");
   a_hold_keeps: assert property (tx_rise && tx_hold_input && !reload_pend_ff |=> $stable(tx_data_ff))
      else $error("tx data moved in hold");
   a_reload_load: assert property (s_reload_seen ##[0:20] load_now
      |=> gen_idx_ff == 5'd0 && gen_ff == $past(pattern_set_ff)) else $error("reload did not load");
   a_first_bit: assert property (first_due_ff && tx_rise && !tx_hold_input && !load_now
      |=> tx_data_ff == gen_ff[0]) else $error("first bit late");
   a_event_latch: assert property (bit_error_evt |=> event_status_ff[BIM_B_BIT_ERR]) else $error("event lost");
   a_level_stays: assert property (rd_end && all_ones_cond |=> event_status_ff[BIM_B_ALL_ONES])
      else $error("live level cleared");
   a_read_clears: assert property (rd_end && rd_snap_ff[BIM_B_BIT_OVF] && !bit_count_ovf_evt
      |=> !event_status_ff[BIM_B_BIT_OVF]) else $error("read did not clear");
   a_style_read: assert property (bus_style_select && !bus_cs_n && !bus_rd_ds_n && !bus_wr_rw
      |=> !bus_data_oe) else $error("drove data on write");
endmodule : bim_top

// *** tb_bim_top.sv ***
// testbench: mask, status latching, interrupt pin and transmit hold/reload
// assumes bim_host as the processor and a tx clock of 8 clk periods
`timescale 1ns/1ps
module tb_bim_top
   import bim_pkg::*;
;
   logic clk, nrst, style, cs_n, rd_ds_n, wr_rw, oe, int_n_out, int_n_oe;
   logic tx_clock, tx_hold, tx_rel, pat_valid, pat_ready, tx_data;
   logic [4:0] addr;
   logic [7:0] din, dout, pat_data, rd;
   logic [6:0] cnd;
   logic [31:0] pat = 32'h3c5a_96e1;
   int miscompares, samples_checked, j;
   bim_host uh (.clk(clk), .style(style), .cs_n(cs_n), .rd_ds_n(rd_ds_n), .wr_rw(wr_rw), .addr(addr),
      .dout(din), .din(dout));
   bim_top uut (.clk(clk), .nrst(nrst), .bus_style_select(style), .bus_cs_n(cs_n), .bus_rd_ds_n(rd_ds_n),
      .bus_wr_rw(wr_rw), .bus_addr(addr), .bus_data_in(din), .bus_data_out(dout), .bus_data_oe(oe),
      .all_ones_cond(cnd[6]), .all_zeros_cond(cnd[5]), .sync_lost_cond(cnd[4]), .bit_error_evt(cnd[3]),
      .bit_count_ovf_evt(cnd[2]), .err_count_ovf_evt(cnd[1]), .sync_state(cnd[0]), .int_n_out(int_n_out),
      .int_n_oe(int_n_oe), .tx_clock(tx_clock), .tx_hold_input(tx_hold), .tx_pattern_reload(tx_rel),
      .pat_valid(pat_valid), .pat_ready(pat_ready), .pat_data(pat_data), .tx_data(tx_data));
   initial begin
      clk = 1'b0;
      forever #(BIM_CLK_NS / 2) clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   // one tx clock period, 4 clk high and 4 low, so the sampler sees every rise
   task automatic tick(input logic hold);
      @(posedge clk);
      tx_hold <= hold;
      tx_clock <= 1'b1;
      repeat (4) @(posedge clk);
      tx_clock <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : tick
   task results;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results
   initial begin
      #(20000 * BIM_CLK_NS);
      miscompares++;
      results;
   end
   initial begin
      {nrst, style, tx_clock, tx_hold, tx_rel, pat_valid, pat_data, cnd} <= '0;
      cyc(4);
      nrst <= 1'b1;
      uh.acc(1'b0, BIM_ADDR_MASK, 8'h00, rd);
      chk(rd, BIM_MASK_RST);
      chk({int_n_oe, int_n_out, tx_data}, 3'b010);
      for (int b = 0; b < 7; b++) begin
         style <= b[0];
         uh.acc(1'b1, BIM_ADDR_MASK, 8'h7f ^ (8'h01 << b), rd);
         @(posedge clk) cnd[b] <= 1'b1;
         @(posedge clk) cnd[b] <= (b == 0);
         cyc(3);
         chk(int_n_oe, 1'b0);
         uh.acc(1'b1, BIM_ADDR_MASK, 8'h80 | (8'h01 << b), rd);
         cyc(3);
         chk({int_n_oe, int_n_out}, 2'b10);
         uh.acc(1'b0, BIM_ADDR_MASK, 8'h00, rd);
         chk(rd, 8'h01 << b);
         uh.acc(1'b0, BIM_ADDR_STATUS, 8'h00, rd);
         chk(rd, 8'h01 << b);
         cnd[0] <= 1'b0;
         cyc(3);
         chk(int_n_oe, 1'b0);
      end
      @(posedge clk) cnd[6] <= 1'b1;
      cyc(2);
      for (int k = 0; k < 4; k++) begin
         uh.acc(1'b0, BIM_ADDR_STATUS, 8'h00, rd);
         chk(rd, (k < 2) ? 8'h40 : 8'h00);
         cyc(3);
         chk(int_n_oe, k == 0);
         cnd[6] <= 1'b0;
      end
      uh.acc(1'b1, 5'h03, 8'h5a, rd);
      uh.acc(1'b1, BIM_ADDR_STATUS, 8'h7e, rd);
      chk(oe, 1'b0);
      uh.acc(1'b0, 5'h03, 8'h00, rd);
      chk(rd, 8'h00);
      uh.acc(1'b0, BIM_ADDR_STATUS, 8'h00, rd);
      chk(rd, 8'h00);
      // four pattern bytes get staged, then filler fills the fifo until it refuses
      for (int i = 0; i < BIM_PAT_BYTES + BIM_FIFO_D; i++) begin
         pat_valid <= 1'b1;
         pat_data <= (i < 4) ? pat[8 * i +: 8] : 8'(i);
         @(posedge clk);
         while (!pat_ready) @(posedge clk);
      end
      pat_valid <= 1'b0;
      cyc(1);
      chk(pat_ready, 1'b0);
      tx_rel <= 1'b1;
      cyc(2);
      tx_rel <= 1'b0;
      cyc(8);
      // staging is only freed when the first tx edge takes the pattern
      chk(pat_ready, 1'b0);
      tick(1'b0);
      chk(tx_data, 1'b0);
      chk(pat_ready, 1'b1);
      j = 0;
      for (int k = 0; k < 10; k++) begin
         tick(k == 5);
         if (k == 5) begin
            chk(tx_data, pat[j - 1]);
         end else begin
            chk(tx_data, pat[j]);
            j++;
         end
      end
      results;
   end
endmodule : tb_bim_top
